// ==== include/eeprom_fe_pkg.sv ====
package eeprom_fe_pkg;
    // ****************************************
    // register map, byte addresses
    // ****************************************
    localparam logic [3:0] OFS_STATUS = 4'h0;
    localparam logic [3:0] OFS_RX = 4'h4;
    localparam logic [3:0] OFS_TX = 4'h8;
    localparam logic [3:0] OFS_CONTROL = 4'hC;
    // status register fields
    localparam int ST_WIP = 0;
    localparam int ST_WEL = 1;
    localparam int ST_PBL = 2;
    localparam int ST_PBH = 3;
    localparam int ST_STATUS_WRITE_DISABLE = 7;
    localparam int ST_SELECTED = 8;
    localparam int ST_PAUSED = 9;
    localparam int ST_RX_VALID = 10;
    localparam int ST_ARMED = 11;
    localparam int ST_STANDBY = 12;
    // rx register fields
    localparam int RX_BYTE_LSB = 0;
    localparam int RX_COUNT_LSB = 8;
    localparam int RX_OPCODE_LSB = 16;
    // control register fields
    localparam int CT_OUT_EN = 0;
    localparam logic CT_OUT_EN_RST = 1'b1;
    localparam logic [7:0] TX_RST = 8'h00;
    // ****************************************
    // serial opcodes
    // ****************************************
    localparam logic [7:0] OP_WREN = 8'h06;
    localparam logic [7:0] OP_WRDI = 8'h04;
    localparam logic [7:0] OP_RDSR = 8'h05;
    localparam logic [7:0] OP_WRSR = 8'h01;
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_WRITE = 8'h02;
    // frame sizes; a read header is opcode + three address bytes
    localparam logic [2:0] READ_HDR_BYTES = 3'h4;
    localparam logic [2:0] WRITE_MIN_BYTES = 3'h5;
    localparam logic [2:0] WRSR_BYTES = 3'h2;
    localparam logic [2:0] BYTE_CNT_MAX = 3'h7;
    localparam logic [2:0] LAST_BIT = 3'h7;
    // ****************************************
    // pin synchroniser lanes
    // ****************************************
    localparam int PIN_COUNT = 5;
    localparam int PIN_SCK = 0;
    localparam int PIN_SDI = 1;
    localparam int PIN_SEL = 2;
    localparam int PIN_PAUSE = 3;
    localparam int PIN_WP = 4;
    localparam logic [PIN_COUNT-1:0] PIN_RST = 5'h00;
    localparam int WIP_CNT_W = 24;
    localparam int WRITE_CYCLES_DEF = 100000;
endpackage : eeprom_fe_pkg

// ==== logic/pin_sync.sv ====
`timescale 1ns/10ps
// ****************************************
// three stage pin sampler with edge flags
// ****************************************
module pin_sync
    import eeprom_fe_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [PIN_COUNT-1:0] pins_in,
    output logic [PIN_COUNT-1:0] level_out,
    output logic [PIN_COUNT-1:0] rise_out,
    output logic [PIN_COUNT-1:0] fall_out
);
    logic [PIN_COUNT-1:0] s1_r;
    logic [PIN_COUNT-1:0] s2_r;
    logic [PIN_COUNT-1:0] s3_r;
    logic [PIN_COUNT-1:0] lvl_r;

    genvar i;
    generate
        for (i = 0; i < PIN_COUNT; i = i + 1) begin : g_lane
            // stage one feeds only stage two
            always_ff @(posedge clk_in or posedge rst_in) begin
                if (rst_in) begin
                    s1_r[i] <= PIN_RST[i];
                    s2_r[i] <= PIN_RST[i];
                    s3_r[i] <= PIN_RST[i];
                    lvl_r[i] <= PIN_RST[i];
                end else begin
                    s1_r[i] <= pins_in[i];
                    s2_r[i] <= s1_r[i];
                    s3_r[i] <= s2_r[i];
                    // change accepted once two and three agree
                    if (s2_r[i] == s3_r[i]) begin
                        lvl_r[i] <= s3_r[i];
                    end
                end
            end
            // edge flags from the accepted level
            assign rise_out[i] = (s2_r[i] == s3_r[i]) & s3_r[i] & ~lvl_r[i];
            assign fall_out[i] = (s2_r[i] == s3_r[i]) & ~s3_r[i] & lvl_r[i];
        end
    endgenerate

    assign level_out = lvl_r;
endmodule : pin_sync

// ==== logic/eeprom_front_end.sv ====
// Local design decisions: the address map and the Avalon-MM register port.
`timescale 1ns/10ps
// Behaviour
// - input bits are taken on a rising serial clock edge
// - output bits are shifted out from a falling serial clock edge
// - select high: deselected, output released, standby unless writing
// - after reset, no selection until select has fallen once
// - bytes arrive MSB first; first bit on first rise after select
// - output MSB first, from first fall after a read instruction
// - works with clock idling low or high
// - reset clears write enable and busy; protect bits keep values
// - no instruction is acted on while reset is applied
// - while paused, output released and clock and data ignored
// - pause may only begin while selected
// - pause begins when pause falls with serial clock low
// - pause ends when pause rises with serial clock low
// - pause keeps bit and byte position untouched
// - deselect while paused resets interface; a complete instruction is still acted on
// - complete write with whole bytes starts write cycle on deselect
// - write protect low with status lock freezes protect bits
// - busy flag high during self timed write, low otherwise
// - acted on only if select rises on a byte boundary
module eeprom_front_end
    import eeprom_fe_pkg::*;
#(
    parameter int unsigned WRITE_CYCLES = WRITE_CYCLES_DEF
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic spi_clk_in,
    input wire logic spi_data_in,
    input wire logic select_n_in,
    input wire logic pause_n_in,
    input wire logic write_protect_n_in,
    output logic spi_data_out,
    output logic spi_data_oe_n_out,
    output logic write_in_progress_out,
    output logic standby_out,
    input wire logic [3:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out
);
    // ****************************************
    // pin sampling
    // ****************************************
    logic [PIN_COUNT-1:0] lvl;
    logic [PIN_COUNT-1:0] rise;
    logic [PIN_COUNT-1:0] fall;

    pin_sync u_sync (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .pins_in({write_protect_n_in, pause_n_in, select_n_in,
                  spi_data_in, spi_clk_in}),
        .level_out(lvl),
        .rise_out(rise),
        .fall_out(fall)
    );

    // ****************************************
    // state
    // ****************************************
    logic armed_r;
    logic paused_r;
    logic [2:0] bit_cnt_r;
    logic [2:0] byte_cnt_r;
    logic [6:0] shift_in_r;
    logic [7:0] rx_byte_r;
    logic [7:0] opcode_r;
    logic rx_valid_r;
    logic [7:0] out_sr_r;
    logic q_r;
    logic q_on_r;
    logic wel_r;
    logic wip_r;
    logic [WIP_CNT_W-1:0] wip_cnt_r;
    logic pbl_r;
    logic pbh_r;
    logic status_write_disable_r;
    logic [7:0] tx_r;
    logic out_en_r;
    logic ack_r;
    logic [31:0] rdata_r;

    // ****************************************
    // link decode
    // ****************************************
    wire sck_low = ~lvl[PIN_SCK];
    wire selected = armed_r & ~lvl[PIN_SEL];
    wire run = selected & ~paused_r;
    wire take_bit = run & rise[PIN_SCK];
    wire give_bit = run & fall[PIN_SCK];
    wire byte_done = take_bit & (bit_cnt_r == LAST_BIT);
    wire [7:0] in_byte = {shift_in_r, lvl[PIN_SDI]};
    wire deselect = armed_r & rise[PIN_SEL];
    wire on_boundary = (bit_cnt_r == 3'h0);
    wire hw_locked = status_write_disable_r & ~lvl[PIN_WP];
    wire [7:0] status_byte = {status_write_disable_r, 3'h0, pbh_r, pbl_r, wel_r, wip_r};

    // read-type phases after the instruction is fully in
    wire rdsr_out = (opcode_r == OP_RDSR) & (byte_cnt_r != 3'h0);
    wire read_out = (opcode_r == OP_READ) & (byte_cnt_r >= READ_HDR_BYTES);
    wire out_phase = rdsr_out | read_out;
    wire [7:0] out_src = rdsr_out ? status_byte : tx_r;

    // instruction acceptance at deselect
    wire act = deselect & on_boundary & ~wip_r;
    wire do_wren = act & (opcode_r == OP_WREN) & (byte_cnt_r == 3'h1);
    wire do_wrdi = act & (opcode_r == OP_WRDI) & (byte_cnt_r == 3'h1);
    wire do_wrsr = act & wel_r & ~hw_locked & (opcode_r == OP_WRSR)
                 & (byte_cnt_r == WRSR_BYTES);
    wire do_write = act & wel_r & (opcode_r == OP_WRITE)
                  & (byte_cnt_r >= WRITE_MIN_BYTES);
    wire start_cycle = do_wrsr | do_write;
    wire wip_end = wip_r & (wip_cnt_r == '0);

    // ****************************************
    // selection guard and pause
    // ****************************************
    // arm only on a real falling edge after reset
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            armed_r <= 1'b0;
        end else if (fall[PIN_SEL]) begin
            armed_r <= 1'b1;
        end
    end

    // pause follows the pin only while selected and clock low
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            paused_r <= 1'b0;
        end else if (!selected) begin
            paused_r <= 1'b0;
        end else if (sck_low) begin
            paused_r <= ~lvl[PIN_PAUSE];
        end
    end

    // ****************************************
    // bit and byte framing
    // ****************************************
    // counters frozen while paused, cleared on select edges
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            bit_cnt_r <= 3'h0;
            byte_cnt_r <= 3'h0;
        end else if (fall[PIN_SEL] || deselect) begin
            bit_cnt_r <= 3'h0;
            byte_cnt_r <= 3'h0;
        end else if (take_bit) begin
            bit_cnt_r <= bit_cnt_r + 3'h1;
            if (byte_done && byte_cnt_r != BYTE_CNT_MAX) begin
                byte_cnt_r <= byte_cnt_r + 3'h1;
            end
        end
    end

    // input shifter, MSB first
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            shift_in_r <= 7'h00;
            rx_byte_r <= 8'h00;
            opcode_r <= 8'h00;
        end else if (fall[PIN_SEL]) begin
            opcode_r <= 8'h00;
        end else if (take_bit) begin
            shift_in_r <= in_byte[6:0];
            if (byte_done) begin
                rx_byte_r <= in_byte;
                if (byte_cnt_r == 3'h0) begin
                    opcode_r <= in_byte;
                end
            end
        end
    end

    // ****************************************
    // output shifter
    // ****************************************
    // load at byte boundary, shift otherwise, on clock fall
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            out_sr_r <= 8'h00;
            q_r <= 1'b0;
            q_on_r <= 1'b0;
        end else if (!selected) begin
            q_on_r <= 1'b0;
        end else if (give_bit && out_phase) begin
            q_on_r <= 1'b1;
            if (on_boundary) begin
                q_r <= out_src[7];
                out_sr_r <= {out_src[6:0], 1'b0};
            end else begin
                q_r <= out_sr_r[7];
                out_sr_r <= {out_sr_r[6:0], 1'b0};
            end
        end
    end

    // released when deselected, paused or not in an output phase
    assign spi_data_out = q_r;
    assign spi_data_oe_n_out = ~(run & q_on_r & out_en_r);

    // ****************************************
    // write enable, busy flag, protect bits
    // ****************************************
    // enable latch: set by a finished WREN, cleared by a finished WRDI or at the end of the write cycle
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            wel_r <= 1'b0;
        end else if (do_wren) begin
            wel_r <= 1'b1;
        end else if (do_wrdi || wip_end) begin
            wel_r <= 1'b0;
        end
    end

    // self timed cycle length
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            wip_r <= 1'b0;
            wip_cnt_r <= '0;
        end else if (start_cycle) begin
            wip_r <= 1'b1;
            wip_cnt_r <= WIP_CNT_W'(WRITE_CYCLES - 1);
        end else if (wip_end) begin
            wip_r <= 1'b0;
        end else if (wip_r) begin
            wip_cnt_r <= wip_cnt_r - 1'b1;
        end
    end

    // nonvolatile bits: untouched by reset
    always_ff @(posedge clk_in) begin
        if (do_wrsr) begin
            status_write_disable_r <= rx_byte_r[ST_STATUS_WRITE_DISABLE];
            pbh_r <= rx_byte_r[ST_PBH];
            pbl_r <= rx_byte_r[ST_PBL];
        end
    end

    assign write_in_progress_out = wip_r;
    assign standby_out = ~selected & ~wip_r;

    // ****************************************
    // avalon slave
    // ****************************************
    wire req = avs_read_in | avs_write_in;
    wire hit_status = avs_address_in == OFS_STATUS;
    wire hit_rx = avs_address_in == OFS_RX;
    wire hit_tx = avs_address_in == OFS_TX;
    wire hit_ctl = avs_address_in == OFS_CONTROL;
    wire wr_lo = avs_write_in & ack_r & avs_byteenable_in[0];
    wire rx_read = avs_read_in & ack_r & hit_rx;

    // status word
    wire [31:0] status_word = {19'h0, standby_out, armed_r, rx_valid_r,
                               paused_r, selected, status_byte};
    wire [31:0] rx_word = {8'h00, opcode_r, 5'h00, byte_cnt_r, rx_byte_r};

    // read multiplexer, unmapped reads zero
    wire [31:0] rmux = hit_status ? status_word :
                       hit_rx ? rx_word :
                       hit_tx ? {24'h0, tx_r} :
                       hit_ctl ? {31'h0, out_en_r} : 32'h0;

    // one wait cycle, answer on the second edge
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            ack_r <= 1'b0;
            rdata_r <= 32'h0;
        end else begin
            ack_r <= req & ~ack_r;
            rdata_r <= rmux;
        end
    end

    assign avs_waitrequest_out = req & ~ack_r;
    assign avs_readdata_out = rdata_r;

    // software registers
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            tx_r <= TX_RST;
            out_en_r <= CT_OUT_EN_RST;
        end else if (wr_lo && hit_tx) begin
            tx_r <= avs_writedata_in[7:0];
        end else if (wr_lo && hit_ctl) begin
            out_en_r <= avs_writedata_in[CT_OUT_EN];
        end
    end

    // new byte flag: set wins over read clear
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rx_valid_r <= 1'b0;
        end else if (byte_done) begin
            rx_valid_r <= 1'b1;
        end else if (rx_read) begin
            rx_valid_r <= 1'b0;
        end
    end
endmodule : eeprom_front_end

// ==== tb/eeprom_fe_checker.sv ====
`timescale 1ns/10ps
// ********
// port checker
// ********
module eeprom_fe_checker
    import eeprom_fe_pkg::*;
#(
    parameter int unsigned WRITE_CYCLES = WRITE_CYCLES_DEF
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic spi_clk_in,
    input wire logic select_n_in,
    input wire logic pause_n_in,
    input wire logic spi_data_out,
    input wire logic spi_data_oe_n_out,
    input wire logic write_in_progress_out,
    input wire logic standby_out
);
    logic [WIP_CNT_W-1:0] busy_cnt_r;
    // length of the current busy stretch
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            busy_cnt_r <= '0;
        end else begin
            busy_cnt_r <= write_in_progress_out ? busy_cnt_r + 1'b1 : '0;
        end
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    sequence sel_hi_s;
        select_n_in [*6];
    endsequence
    sequence paused_s;
        (!pause_n_in && !select_n_in && !spi_clk_in) [*7];
    endsequence
    AST_OE_DESEL: assert property (sel_hi_s |-> spi_data_oe_n_out)
        else $error("output driven while deselected");
    AST_STANDBY: assert property (
        sel_hi_s ##0 !write_in_progress_out |-> standby_out)
        else $error("no standby while deselected and idle");
    AST_PAUSE_OE: assert property (paused_s |-> spi_data_oe_n_out)
        else $error("output driven while paused");
    AST_PAUSE_FREEZE: assert property (
        paused_s ##1 (!pause_n_in && !select_n_in) [*8]
        |-> $stable(spi_data_out))
        else $error("output moved while paused");
    AST_OUT_ON_FALL: assert property (
        $changed(spi_data_out) && !spi_data_oe_n_out |-> !spi_clk_in)
        else $error("output changed while serial clock high");
    AST_WIP_AFTER_DESEL: assert property (
        $rose(write_in_progress_out) |-> select_n_in)
        else $error("write cycle started while selected");
    AST_WIP_MIN: assert property (
        $rose(write_in_progress_out) |-> write_in_progress_out [*8])
        else $error("busy flag dropped early");
    AST_WIP_LEN: assert property ($fell(write_in_progress_out)
        |-> $past(busy_cnt_r) >= WRITE_CYCLES - 1
        && $past(busy_cnt_r) <= WRITE_CYCLES + 1)
        else $error("busy length wrong");
    AST_RST_STATE: assert property ($fell(rst_in)
        |-> spi_data_oe_n_out && !write_in_progress_out && standby_out)
        else $error("wrong state after reset");
endmodule : eeprom_fe_checker

bind eeprom_front_end eeprom_fe_checker #(.WRITE_CYCLES(WRITE_CYCLES)) chk_i (
    .clk_in(clk_in), .rst_in(rst_in), .spi_clk_in(spi_clk_in),
    .select_n_in(select_n_in), .pause_n_in(pause_n_in),
    .spi_data_out(spi_data_out), .spi_data_oe_n_out(spi_data_oe_n_out),
    .write_in_progress_out(write_in_progress_out),
    .standby_out(standby_out)
);

// ==== tb/spi_master_model.sv ====
`timescale 1ns/10ps
// ********
// serial bus master
// ********
module spi_master_model (
    input wire logic clk_in,
    input wire logic miso_in,
    input wire logic miso_oe_n_in,
    output logic sck_out,
    output logic mosi_out,
    output logic sel_n_out,
    output logic pause_n_out,
    output logic wp_n_out
);
    localparam realtime HALF = 62.5; // half of a 125 ns link clock
    logic cpol = 1'b0;
    // select low from power-up
    initial begin
        sck_out = 1'b0;
        mosi_out = 1'b0;
        sel_n_out = 1'b0;
        pause_n_out = 1'b1;
        wp_n_out = 1'b1;
    end
    task wait_h;
        #HALF;
    endtask : wait_h
    // data set while clock low, taken at rise
    task bit_x(input logic b, output logic r);
        sck_out <= 1'b0;
        mosi_out <= b;
        wait_h;
        // released line reads back inverted, never as a stale value
        r = (miso_oe_n_in === 1'b0) ? miso_in : ~miso_in;
        sck_out <= 1'b1;
        wait_h;
    endtask : bit_x
    task xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) bit_x(tx[i], rx[i]);
    endtask : xfer
    task start;
        @(posedge clk_in);
        sck_out <= cpol;
        sel_n_out <= 1'b1;
        wait_h;
        sel_n_out <= 1'b0;
        wait_h;
    endtask : start
    // deselect after last rise, data line scrambled
    task stop;
        sck_out <= cpol;
        wait_h;
        sel_n_out <= 1'b1;
        mosi_out <= ~mosi_out;
        wait_h;
    endtask : stop
    task pause(input logic on);
        sck_out <= 1'b0;
        wait_h;
        pause_n_out <= !on;
        wait_h;
    endtask : pause
    task set_wp(input logic v);
        wp_n_out <= v;
        wait_h;
    endtask : set_wp
endmodule : spi_master_model

// ==== tb/spi_eeprom_serial_front_end_tb.sv ====
`timescale 1ns/10ps
// ********
// front end bench
// ********
module spi_eeprom_serial_front_end_tb;
    import eeprom_fe_pkg::*;
    localparam int WC = 20;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic sck, mosi, sel_n, pause_n, wp_n, sdo, oe_n, write_in_progress, stby, wreq;
    logic [3:0] addr, be;
    logic rd, wr;
    logic [31:0] wdata;
    logic [31:0] rdata, q;
    logic [7:0] rx;
    logic b;
    int n_mismatch = 0;
    int total_checks = 0;
    always #5 clk_in = ~clk_in;
    eeprom_front_end #(.WRITE_CYCLES(WC)) dut (
        .clk_in(clk_in), .rst_in(rst_in), .spi_clk_in(sck),
        .spi_data_in(mosi), .select_n_in(sel_n), .pause_n_in(pause_n),
        .write_protect_n_in(wp_n), .spi_data_out(sdo),
        .spi_data_oe_n_out(oe_n), .write_in_progress_out(write_in_progress),
        .standby_out(stby), .avs_address_in(addr), .avs_read_in(rd),
        .avs_write_in(wr), .avs_writedata_in(wdata),
        .avs_byteenable_in(be), .avs_readdata_out(rdata),
        .avs_waitrequest_out(wreq));
    spi_master_model m (.clk_in(clk_in), .miso_in(sdo),
        .miso_oe_n_in(oe_n), .sck_out(sck), .mosi_out(mosi),
        .sel_n_out(sel_n), .pause_n_out(pause_n), .wp_n_out(wp_n));
    task give_verdict;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : give_verdict
    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // one bus cycle, held until waitrequest low
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_in);
        addr <= a;
        wdata <= d;
        rd <= !w;
        wr <= w;
        do @(posedge clk_in); while (wreq !== 1'b0);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus
    task stb(input int pos, input logic e);
        bus(1'b0, OFS_STATUS, 32'h0);
        chk({31'h0, q[pos]}, {31'h0, e});
    endtask : stb
    task cmd(input logic [7:0] op, input logic [31:0] arg, input int n);
        m.start;
        m.xfer(op, rx);
        for (int i = 0; i < n; i++) m.xfer(arg[31-8*i -: 8], rx);
        m.stop;
    endtask : cmd
    task idle;
        for (int i = 0; i < 400 && write_in_progress !== 1'b0; i++) @(posedge clk_in);
        chk({31'h0, write_in_progress}, 32'h0);
    endtask : idle
    task t_reset;
        bus(1'b0, OFS_STATUS, 32'h0);
        chk(q & 32'h1003, 32'h1000);
        bus(1'b0, OFS_CONTROL, 32'h0);
        chk(q, {31'h0, CT_OUT_EN_RST});
        bus(1'b0, 4'h2, 32'h0);
        chk(q, 32'h0);
        bus(1'b1, OFS_TX, 32'h5A);
        bus(1'b0, OFS_TX, 32'h0);
        chk(q, 32'h5A);
        chk({31'h0, stby}, 32'h1);
        be <= 4'h0;
        bus(1'b1, OFS_TX, 32'h33);
        be <= 4'hF;
        bus(1'b0, OFS_TX, 32'h0);
        chk(q, 32'h5A);
        $display("t_reset done");
    endtask : t_reset
    task t_arm;
        m.xfer(OP_WREN, rx);
        m.stop;
        stb(ST_WEL, 1'b0);
        $display("t_arm done");
    endtask : t_arm
    task t_modes;
        for (int md = 0; md < 2; md++) begin
            m.cpol = md[0];
            cmd(OP_WREN, 32'h0, 0);
            stb(ST_WEL, 1'b1);
            cmd(OP_WRDI, 32'h0, 0);
            stb(ST_WEL, 1'b0);
        end
        m.start;
        m.xfer(OP_WREN, rx);
        m.bit_x(1'b0, b);
        m.stop;
        stb(ST_WEL, 1'b0);
        $display("t_modes done");
    endtask : t_modes
    task t_status;
        m.cpol = 1'b1;
        cmd(OP_WREN, 32'h0, 0);
        cmd(OP_WRSR, 32'h8C000000, 1);
        stb(ST_WIP, 1'b1);
        idle;
        stb(ST_WEL, 1'b0);
        cmd(OP_RDSR, 32'h0, 2);
        chk({24'h0, rx}, 32'h8C);
        m.cpol = 1'b0;
        cmd(OP_RDSR, 32'h0, 1);
        chk({24'h0, rx}, 32'h8C);
        m.set_wp(1'b0);
        cmd(OP_WREN, 32'h0, 0);
        cmd(OP_WRSR, 32'h0, 1);
        idle;
        cmd(OP_RDSR, 32'h0, 1);
        chk({24'h0, rx & 8'h8C}, 32'h8C);
        m.set_wp(1'b1);
        cmd(OP_WREN, 32'h0, 0);
        cmd(OP_WRSR, 32'h0, 1);
        idle;
        cmd(OP_RDSR, 32'h0, 1);
        chk({24'h0, rx}, 32'h0);
        cmd(OP_READ, 32'h0, 4);
        chk({24'h0, rx}, 32'h5A);
        bus(1'b1, OFS_CONTROL, 32'h0);
        m.start;
        m.xfer(OP_RDSR, rx);
        m.bit_x(1'b0, b);
        chk({31'h0, oe_n}, 32'h1);
        m.stop;
        bus(1'b1, OFS_CONTROL, 32'h1);
        $display("t_status done");
    endtask : t_status
    task t_pause;
        m.start;
        m.xfer(OP_RDSR, rx);
        m.bit_x(1'b0, b);
        chk({31'h0, oe_n}, 32'h0);
        chk({31'h0, stby}, 32'h0);
        m.pause(1'b1);
        chk({31'h0, oe_n}, 32'h1);
        m.pause(1'b0);
        m.stop;
        m.start;
        for (int i = 7; i > 3; i--) m.bit_x(OP_WREN[i], b);
        m.pause(1'b1);
        chk({31'h0, oe_n}, 32'h1);
        repeat (3) m.bit_x(1'b1, b);
        m.pause(1'b0);
        for (int i = 3; i >= 0; i--) m.bit_x(OP_WREN[i], b);
        m.stop;
        stb(ST_WEL, 1'b1);
        m.start;
        for (int i = 7; i > 4; i--) m.bit_x(OP_WRDI[i], b);
        m.pause(1'b1);
        m.stop;
        m.pause(1'b0);
        stb(ST_WEL, 1'b1);
        cmd(OP_WRDI, 32'h0, 0);
        stb(ST_WEL, 1'b0);
        $display("t_pause done");
    endtask : t_pause
    task t_write;
        cmd(OP_WREN, 32'h0, 0);
        m.start;
        m.xfer(OP_WRITE, rx);
        repeat (4) m.xfer(8'hA5, rx);
        m.pause(1'b1);
        m.stop;
        stb(ST_WIP, 1'b1);
        m.pause(1'b0);
        idle;
        stb(ST_WEL, 1'b0);
        stb(ST_RX_VALID, 1'b1);
        bus(1'b0, OFS_RX, 32'h0);
        chk(q, 32'h000200A5);
        stb(ST_RX_VALID, 1'b0);
        $display("t_write done");
    endtask : t_write
    // reset in mid-run: volatile bits cleared, protect bits kept
    task t_rst2;
        cmd(OP_WREN, 32'h0, 0);
        cmd(OP_WRSR, 32'h0C000000, 1);
        idle;
        cmd(OP_WREN, 32'h0, 0);
        @(posedge clk_in);
        rst_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        rst_in <= 1'b0;
        bus(1'b0, OFS_STATUS, 32'h0);
        chk(q & 32'h1FFF, 32'h100C);
        $display("t_rst2 done");
    endtask : t_rst2
    // hang guard
    initial begin
        #600000;
        n_mismatch++;
        give_verdict;
    end
    initial begin
        addr <= 4'h0;
        be <= 4'hF;
        rd <= 1'b0;
        wr <= 1'b0;
        wdata <= 32'h0;
        repeat (2) @(posedge clk_in);
        rst_in <= 1'b0;
        @(posedge clk_in);
        t_reset;
        t_arm;
        t_modes;
        t_status;
        t_pause;
        t_write;
        t_rst2;
        give_verdict;
    end
endmodule : spi_eeprom_serial_front_end_tb
